//--- design/mirror_mode_ctrl.sv
// mirror array controller mode control with apb register access
`timescale 1ns/1ps
`default_nettype none

module mirror_mode_ctrl
(
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [11:0]                             paddr,
    input  wire logic [31:0]                             pwdata,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire logic [7:0]                              mode_switch_bank,
    output mirror_ctrl_pkg::mode_s                       mode_out,
    output mirror_ctrl_pkg::addr_s                       addr_out,
    output logic                                         power_park_request,
    output logic                                         test_pattern_mode,
    output logic [mirror_ctrl_pkg::PATTERN_W-1:0]        pattern_index,
    output logic [mirror_ctrl_pkg::ROW_W-1:0]            row_data,
    output logic                                         row_load_strobe,
    output logic                                         general_out_0,
    output logic                                         general_out_1,
    output logic                                         general_out_2
);

    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;
    logic        rd_wait_ff;
    logic [7:0]  sw_ff;
    logic [7:0]  sw_value_ff;
    logic [7:0]  toggle_ff;
    logic        override_ff;
    logic        test_en_ff;
    logic        park_ff;
    logic [2:0]  gp_ff;
    logic [2:0]  pattern_sel_ff;
    logic [2:0]  rr_ff;
    logic [11:0] dwell_ff;
    logic [15:0] row_word_ff;
    logic        row_load_ff;
    logic [7:0]  eff_bits;
    mirror_ctrl_pkg::mode_s mode_ff;
    mirror_ctrl_pkg::addr_s addr_ff;

    // writes finish in their first access cycle; reads take one wait state so
    // that prdata comes from a flip-flop and already stands when pready is high
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = !rd_en || rd_wait_ff;
    assign pslverr = psel && penable && !addr_hit;

    always_comb
    begin
        unique case (paddr)
            mirror_ctrl_pkg::ADDR_CTRL, mirror_ctrl_pkg::ADDR_SW_VALUE,
            mirror_ctrl_pkg::ADDR_EFFECTIVE, mirror_ctrl_pkg::ADDR_ROW_MODE,
            mirror_ctrl_pkg::ADDR_ROW_ADDR, mirror_ctrl_pkg::ADDR_BLK_MODE,
            mirror_ctrl_pkg::ADDR_BLK_ADDR, mirror_ctrl_pkg::ADDR_TOGGLE,
            mirror_ctrl_pkg::ADDR_GP_OUT, mirror_ctrl_pkg::ADDR_LOAD_ROW,
            mirror_ctrl_pkg::ADDR_PATTERN, mirror_ctrl_pkg::ADDR_STATUS:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    end

    // high for the second access cycle of a read only; drops at its closing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_wait_ff <= 1'b0;
        else
            rd_wait_ff <= rd_en && !rd_wait_ff;
    end

    // switch bank sampled once per clock, inputs are synchronous
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sw_ff <= mirror_ctrl_pkg::SW_VALUE_RESET;
        else
            sw_ff <= mode_switch_bank;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            override_ff <= 1'b0;
            sw_value_ff <= mirror_ctrl_pkg::SW_VALUE_RESET;
        end
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_CTRL)
            override_ff <= pwdata[mirror_ctrl_pkg::CTRL_OVERRIDE_BIT];
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_SW_VALUE)
            sw_value_ff <= pwdata[7:0];
    end

    // toggle mask: each written one flips that mode input once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            toggle_ff <= 8'h00;
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_TOGGLE)
            toggle_ff <= toggle_ff ^ pwdata[7:0];
        else if (wr_en && (paddr == mirror_ctrl_pkg::ADDR_SW_VALUE
                           || paddr == mirror_ctrl_pkg::ADDR_CTRL))
            toggle_ff <= 8'h00;
    end

    always_comb
    begin
        eff_bits = override_ff ? sw_value_ff : sw_ff;
        eff_bits = eff_bits ^ toggle_ff;
    end

    // registered mode outputs; watchdog forces the reset type to RST_SINGLE (code 0)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_ff <= '0;
        else
        begin
            mode_ff <= mirror_ctrl_pkg::decode_switches(eff_bits);
            if (eff_bits[mirror_ctrl_pkg::SW_WATCHDOG])
                mode_ff.reset_type <= mirror_ctrl_pkg::RST_SINGLE;
        end
    end

    // direct set writes, applied on the accepting edge with no queueing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_ff.row_load_mode        <= mirror_ctrl_pkg::ROW_MODE_RESET;
            addr_ff.row_select_address   <= '0;
            addr_ff.block_op_mode        <= mirror_ctrl_pkg::BLK_MODE_RESET;
            addr_ff.block_select_address <= '0;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                mirror_ctrl_pkg::ADDR_ROW_MODE:
                    addr_ff.row_load_mode <= pwdata[1:0];
                mirror_ctrl_pkg::ADDR_ROW_ADDR:
                    addr_ff.row_select_address <= pwdata[mirror_ctrl_pkg::ROW_ADDR_W-1:0];
                mirror_ctrl_pkg::ADDR_BLK_MODE:
                    addr_ff.block_op_mode <= pwdata[1:0];
                mirror_ctrl_pkg::ADDR_BLK_ADDR:
                    addr_ff.block_select_address <= pwdata[mirror_ctrl_pkg::BLK_ADDR_W-1:0];
                default:
                    addr_ff <= addr_ff;
            endcase
        end
    end

    // park latches; only presetn (application logic reset) releases it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            park_ff <= 1'b0;
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_CTRL
                 && pwdata[mirror_ctrl_pkg::CTRL_PARK_BIT])
            park_ff <= 1'b1;
    end

    // script start wins over a simultaneous test-mode enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            test_en_ff <= 1'b0;
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_CTRL)
            test_en_ff <= pwdata[mirror_ctrl_pkg::CTRL_TEST_EN_BIT]
                          && !pwdata[mirror_ctrl_pkg::CTRL_SCRIPT_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gp_ff <= 3'h0;
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_GP_OUT)
            gp_ff <= pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pattern_sel_ff <= 3'h0;
        else if (wr_en && paddr == mirror_ctrl_pkg::ADDR_PATTERN)
            pattern_sel_ff <= pwdata[mirror_ctrl_pkg::PATTERN_W-1:0];
    end

    // round-robin walker; counter halt freezes it on the current pattern
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rr_ff    <= 3'h0;
            dwell_ff <= 12'h000;
        end
        else if (test_en_ff && pattern_sel_ff == mirror_ctrl_pkg::PATTERN_ALL
                 && !mode_ff.counter_halt)
        begin
            if (dwell_ff == mirror_ctrl_pkg::DWELL_LAST)
            begin
                dwell_ff <= 12'h000;
                rr_ff    <= (rr_ff == mirror_ctrl_pkg::PATTERN_COUNT - 3'h1)
                            ? 3'h0 : rr_ff + 3'h1;
            end
            else
                dwell_ff <= dwell_ff + 12'h001;
        end
    end

    // one row per command: host word repeated across the full row width
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            row_word_ff <= 16'h0000;
            row_load_ff <= 1'b0;
        end
        else
        begin
            row_load_ff <= wr_en && paddr == mirror_ctrl_pkg::ADDR_LOAD_ROW;
            if (wr_en && paddr == mirror_ctrl_pkg::ADDR_LOAD_ROW)
                row_word_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en && !rd_wait_ff)
        begin
            unique case (paddr)
                mirror_ctrl_pkg::ADDR_CTRL:
                    prdata <= {28'h0, park_ff, 1'b0, test_en_ff, override_ff};
                mirror_ctrl_pkg::ADDR_SW_VALUE:  prdata <= {24'h0, sw_value_ff};
                mirror_ctrl_pkg::ADDR_EFFECTIVE: prdata <= {24'h0, eff_bits};
                mirror_ctrl_pkg::ADDR_ROW_MODE:
                    prdata <= {30'h0, addr_ff.row_load_mode};
                mirror_ctrl_pkg::ADDR_ROW_ADDR:
                    prdata <= {21'h0, addr_ff.row_select_address};
                mirror_ctrl_pkg::ADDR_BLK_MODE:
                    prdata <= {30'h0, addr_ff.block_op_mode};
                mirror_ctrl_pkg::ADDR_BLK_ADDR:
                    prdata <= {28'h0, addr_ff.block_select_address};
                mirror_ctrl_pkg::ADDR_TOGGLE:    prdata <= {24'h0, toggle_ff};
                mirror_ctrl_pkg::ADDR_GP_OUT:    prdata <= {29'h0, gp_ff};
                mirror_ctrl_pkg::ADDR_LOAD_ROW:  prdata <= {16'h0, row_word_ff};
                mirror_ctrl_pkg::ADDR_PATTERN:   prdata <= {29'h0, pattern_sel_ff};
                mirror_ctrl_pkg::ADDR_STATUS:
                    prdata <= {24'h0, mode_ff};
                default:                         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // prdata is loaded at the first access edge and held through the wait state,
    // so the value taken with pready is never one that is still changing
    assign mode_out           = mode_ff;
    assign addr_out           = addr_ff;
    assign power_park_request = park_ff;
    assign test_pattern_mode  = test_en_ff;
    assign pattern_index      = (pattern_sel_ff == mirror_ctrl_pkg::PATTERN_ALL)
                                ? rr_ff : pattern_sel_ff;
    assign row_data           = {mirror_ctrl_pkg::ROW_WORDS{row_word_ff}};
    assign row_load_strobe    = row_load_ff;
    assign general_out_0      = gp_ff[0];
    assign general_out_1      = gp_ff[1];
    assign general_out_2      = gp_ff[2];

endmodule

`default_nettype wire

//--- shared/mirror_ctrl_pkg.sv
// package: register map, field layout and reset values of the mirror mode control block
package mirror_ctrl_pkg;

    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_SW_VALUE  = 12'h004;
    localparam logic [11:0] ADDR_EFFECTIVE = 12'h008;
    localparam logic [11:0] ADDR_ROW_MODE  = 12'h00c;
    localparam logic [11:0] ADDR_ROW_ADDR  = 12'h010;
    localparam logic [11:0] ADDR_BLK_MODE  = 12'h014;
    localparam logic [11:0] ADDR_BLK_ADDR  = 12'h018;
    localparam logic [11:0] ADDR_TOGGLE    = 12'h01c;
    localparam logic [11:0] ADDR_GP_OUT    = 12'h020;
    localparam logic [11:0] ADDR_LOAD_ROW  = 12'h024;
    localparam logic [11:0] ADDR_PATTERN   = 12'h028;
    localparam logic [11:0] ADDR_STATUS    = 12'h02c;

    // ctrl register bits
    localparam int CTRL_OVERRIDE_BIT = 0;
    localparam int CTRL_TEST_EN_BIT  = 1;
    localparam int CTRL_SCRIPT_BIT   = 2;   // write-one pulse: script start
    localparam int CTRL_PARK_BIT     = 3;   // write-one: power park request

    // switch bank bit positions (position n sits at bit n-1)
    localparam int SW_FLOAT     = 0;
    localparam int SW_HALT      = 1;
    localparam int SW_COMPL     = 2;
    localparam int SW_FLIP      = 3;
    localparam int SW_RST_LSB   = 4;
    localparam int SW_RST_MSB   = 5;
    localparam int SW_ROW_SELECT_ADDRESS   = 6;
    localparam int SW_WATCHDOG  = 7;

    // reset type codes
    localparam logic [1:0] RST_SINGLE = 2'h0;
    localparam logic [1:0] RST_DUAL   = 2'h1;
    localparam logic [1:0] RST_GLOBAL = 2'h2;
    localparam logic [1:0] RST_QUAD   = 2'h3;

    localparam logic [7:0] SW_VALUE_RESET = 8'h00;
    localparam logic [1:0] ROW_MODE_RESET = 2'h0;
    localparam logic [1:0] BLK_MODE_RESET = 2'h0;
    localparam int         ROW_ADDR_W     = 11;
    localparam int         BLK_ADDR_W     = 4;
    localparam int         PATTERN_W      = 3;
    localparam logic [2:0] PATTERN_COUNT  = 3'h7;  // stored patterns 0..6, code 7 = all
    localparam logic [2:0] PATTERN_ALL    = 3'h7;
    localparam int         ROW_WORDS      = 4;     // 16-bit words across the row bus
    localparam int         ROW_W          = 16 * ROW_WORDS;
    localparam int         DWELL_CYCLES   = 4000;  // round-robin dwell per pattern
    localparam logic [11:0] DWELL_LAST    = 12'(DWELL_CYCLES - 1);

    typedef struct packed {
        logic       float_all;
        logic       counter_halt;
        logic       complement;
        logic       ns_flip;
        logic [1:0] reset_type;
        logic       row_addr_mode;
        logic       watchdog_en;
    } mode_s;

    typedef struct packed {
        logic [1:0]            row_load_mode;
        logic [ROW_ADDR_W-1:0] row_select_address;
        logic [1:0]            block_op_mode;
        logic [BLK_ADDR_W-1:0] block_select_address;
    } addr_s;

    function automatic mode_s decode_switches(input logic [7:0] sw);
        mode_s m;
        m.float_all     = sw[SW_FLOAT];
        m.counter_halt  = sw[SW_HALT];
        m.complement    = sw[SW_COMPL];
        m.ns_flip       = sw[SW_FLIP];
        m.reset_type    = {sw[SW_RST_MSB], sw[SW_RST_LSB]};
        m.row_addr_mode = sw[SW_ROW_SELECT_ADDRESS];
        m.watchdog_en   = sw[SW_WATCHDOG];
        return m;
    endfunction

endpackage

//--- verif/mirror_mode_ctrl_sva.sv
// assertions on the ports of the mirror mode control block
`timescale 1ns/1ps
`default_nettype none
module mirror_mode_ctrl_sva
(
    input wire logic                                pclk,
    input wire logic                                presetn,
    input wire logic                                psel,
    input wire logic                                penable,
    input wire logic                                pwrite,
    input wire logic [11:0]                         paddr,
    input wire logic [31:0]                         pwdata,
    input wire logic                                pslverr,
    input wire mirror_ctrl_pkg::mode_s              mode_out,
    input wire mirror_ctrl_pkg::addr_s              addr_out,
    input wire logic                                power_park_request,
    input wire logic                                test_pattern_mode,
    input wire logic [mirror_ctrl_pkg::ROW_W-1:0]   row_data,
    input wire logic                                row_load_strobe,
    input wire logic                                general_out_0,
    input wire logic                                general_out_1,
    input wire logic                                general_out_2
);
    logic ld_wr_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ld_wr_ff <= 1'b0;
        else
            ld_wr_ff <= psel && penable && pwrite && paddr == mirror_ctrl_pkg::ADDR_LOAD_ROW;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_to(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence ctrl_bit(int b);
        wr_to(mirror_ctrl_pkg::ADDR_CTRL) ##0 pwdata[b];
    endsequence
    park_sticky_a: assert property (power_park_request |=> power_park_request)
        else $error("park request dropped without reset");
    park_set_a: assert property (ctrl_bit(3) |=> power_park_request)
        else $error("park write did not raise park request");
    script_user_a: assert property (ctrl_bit(2) |=> !test_pattern_mode)
        else $error("script start left test pattern mode on");
    test_mode_a: assert property (ctrl_bit(1) ##0 !pwdata[2] |=> test_pattern_mode)
        else $error("test enable write ignored");
    gp_out_a: assert property (wr_to(mirror_ctrl_pkg::ADDR_GP_OUT) |=>
        {general_out_2, general_out_1, general_out_0} == $past(pwdata[2:0]))
        else $error("general outputs differ from written bits");
    row_fill_a: assert property (wr_to(mirror_ctrl_pkg::ADDR_LOAD_ROW) |=>
        row_load_strobe && row_data == {4{$past(pwdata[15:0])}})
        else $error("row load strobe or data wrong");
    strobe_cause_a: assert property (row_load_strobe |-> ld_wr_ff)
        else $error("row strobe without load write");
    row_mode_a: assert property (wr_to(mirror_ctrl_pkg::ADDR_ROW_MODE) |=>
        addr_out.row_load_mode == $past(pwdata[1:0]))
        else $error("row mode not applied");
    blk_addr_a: assert property (wr_to(mirror_ctrl_pkg::ADDR_BLK_ADDR) |=>
        addr_out.block_select_address == $past(pwdata[3:0]))
        else $error("block address not applied");
    wdt_reset_a: assert property (mode_out.watchdog_en |-> mode_out.reset_type == 2'h0)
        else $error("watchdog on with another reset type");
    bad_addr_a: assert property (psel && penable && paddr > mirror_ctrl_pkg::ADDR_STATUS |-> pslverr)
        else $error("unmapped access without error");
endmodule
`default_nettype wire

//--- verif/mirror_array_model.sv
// behavioural model of the controller chip inputs: counts loaded rows and keeps the last one
`timescale 1ns/1ps
`default_nettype none
module mirror_array_model
(
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic [mirror_ctrl_pkg::ROW_W-1:0]   row_data,
    input  wire logic                                row_load_strobe,
    output var  int                                  rows_seen,
    output var  logic [mirror_ctrl_pkg::ROW_W-1:0]   last_row
);
    // a row is taken only on the strobe, so extra pulses show up in the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rows_seen <= 0;
            last_row  <= '0;
        end
        else if (row_load_strobe)
        begin
            rows_seen <= rows_seen + 1;
            last_row  <= row_data;
        end
    end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking testbench for the mirror mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, park, tpm, strobe, g0, g1, g2;
    logic [7:0]  sw = 8'h00;
    logic [2:0]  pidx;
    logic [63:0] row_data, last_row;
    int          rows_seen, bad_count = 0, n_tests = 0;
    mirror_ctrl_pkg::mode_s mode_out;
    mirror_ctrl_pkg::addr_s addr_out;
    mirror_mode_ctrl mirror_mode_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_switch_bank(sw), .mode_out(mode_out),
        .addr_out(addr_out), .power_park_request(park), .test_pattern_mode(tpm),
        .pattern_index(pidx), .row_data(row_data), .row_load_strobe(strobe),
        .general_out_0(g0), .general_out_1(g1), .general_out_2(g2));
    mirror_array_model mirror_array_model_i (.pclk(pclk), .presetn(presetn),
        .row_data(row_data), .row_load_strobe(strobe), .rows_seen(rows_seen),
        .last_row(last_row));
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // request held until pready is seen at a rising edge; read data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin bad_count++; end_sim(); end
        er = pslverr;
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(negedge pclk);
    endtask
    function automatic logic [7:0] exp_mode(input logic [7:0] s);
        logic [7:0] m;
        m = {s[0], s[1], s[2], s[3], s[5], s[4], s[6], s[7]};
        if (s[7]) m[3:2] = 2'h0;
        return m;
    endfunction
    task automatic t_switch();
        logic [7:0] v[11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h40,
                              8'h80, 8'hb0, 8'h00};
        foreach (v[i])
        begin
            @(posedge pclk); sw <= v[i];
            cyc(3);
            `CHK(mode_out, exp_mode(v[i]))
        end
    endtask
    task automatic t_override();
        @(posedge pclk); sw <= 8'hff;
        apb(1, mirror_ctrl_pkg::ADDR_SW_VALUE, 32'h5);
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h1);
        cyc(2); `CHK(mode_out, exp_mode(8'h05))
        apb(1, mirror_ctrl_pkg::ADDR_TOGGLE, 32'h2);
        cyc(2); `CHK(mode_out, exp_mode(8'h07))
        apb(1, mirror_ctrl_pkg::ADDR_TOGGLE, 32'h2);
        cyc(2); `CHK(mode_out, exp_mode(8'h05))
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h0);
        cyc(3); `CHK(mode_out, exp_mode(8'hff))
        @(posedge pclk); sw <= 8'h00;
    endtask
    task automatic t_direct();
        logic [11:0] a[4] = '{mirror_ctrl_pkg::ADDR_ROW_MODE, mirror_ctrl_pkg::ADDR_ROW_ADDR,
                              mirror_ctrl_pkg::ADDR_BLK_MODE, mirror_ctrl_pkg::ADDR_BLK_ADDR};
        logic [31:0] v[4] = '{32'h2, 32'h5a5, 32'h1, 32'hc};
        foreach (a[i]) apb(1, a[i], v[i]);
        `CHK(addr_out, {2'h2, 11'h5a5, 2'h1, 4'hc})
        foreach (a[i])
        begin
            apb(0, a[i], 32'h0); `CHK(rd, v[i])
        end
        apb(0, 12'h030, 32'h0); `CHK({er, rd}, {1'b1, 32'h0})
    endtask
    task automatic t_gp_row();
        apb(1, mirror_ctrl_pkg::ADDR_GP_OUT, 32'hfd); `CHK({g2, g1, g0}, 3'h5)
        apb(1, mirror_ctrl_pkg::ADDR_GP_OUT, 32'h2); `CHK({g2, g1, g0}, 3'h2)
        apb(1, mirror_ctrl_pkg::ADDR_LOAD_ROW, 32'hbeef5a5a);
        cyc(3); `CHK(rows_seen, 1)
        `CHK(last_row, 64'h5a5a5a5a5a5a5a5a)
    endtask
    task automatic t_pattern();
        logic [2:0] p;
        int k;
        apb(1, mirror_ctrl_pkg::ADDR_PATTERN, 32'h3);
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h2);
        cyc(2); `CHK({tpm, pidx}, {1'b1, 3'h3})
        apb(1, mirror_ctrl_pkg::ADDR_PATTERN, 32'h7);
        repeat (8)
        begin
            p = pidx; k = 0;
            while (pidx === p && k < mirror_ctrl_pkg::DWELL_CYCLES + 8) begin cyc(0); cyc(1); k++; end
            `CHK(pidx, (p == 3'h6) ? 3'h0 : p + 3'h1)
        end
        // counter halt must hold the walker for longer than one dwell
        @(posedge pclk); sw <= 8'h02;
        cyc(3); p = pidx;
        repeat (mirror_ctrl_pkg::DWELL_CYCLES + 8) @(posedge pclk);
        cyc(0); `CHK(pidx, p)
        @(posedge pclk); sw <= 8'h00;
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h4);
        cyc(2); `CHK(tpm, 1'b0)
    endtask
    task automatic t_park();
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h8);
        apb(1, mirror_ctrl_pkg::ADDR_CTRL, 32'h0);
        cyc(2); `CHK(park, 1'b1)
        @(posedge pclk); presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2); `CHK({park, g1, mode_out}, 10'h0)
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cyc(1);
        t_switch();
        t_override();
        t_direct();
        t_gp_row();
        t_pattern();
        t_park();
        end_sim();
    end
    initial
    begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        end_sim();
    end
endmodule
bind mirror_mode_ctrl mirror_mode_ctrl_sva mirror_mode_ctrl_sva_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .mode_out(mode_out), .addr_out(addr_out),
    .power_park_request(power_park_request), .test_pattern_mode(test_pattern_mode),
    .row_data(row_data), .row_load_strobe(row_load_strobe), .general_out_0(general_out_0),
    .general_out_1(general_out_1), .general_out_2(general_out_2));
`default_nettype wire
